/* verilog/peo_edge_offset_regs.sv */
`timescale 1ns/1ns
module peo_edge_offset_regs (
   input  wire logic                  clk_sys,
   input  wire logic                  rst,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [7:0]            reg_addr,
   input  wire logic [7:0]            reg_wdata,
   output logic      [7:0]            reg_rdata,
   output logic                       reg_ack,
   output logic                       reg_hit,
   input  wire logic                  period_start,
   output logic                       edge5_direction,
   output logic      [2:0]            edge5_shift,
   output logic signed [6:0]          edge5_offset_ns,
   output logic                       edge6_direction,
   output logic      [2:0]            edge6_shift,
   output logic signed [6:0]          edge6_offset_ns,
   output logic                       edge7_direction,
   output logic      [2:0]            edge7_shift,
   output logic signed [6:0]          edge7_offset_ns,
   output logic                       edge8_direction,
   output logic      [2:0]            edge8_shift,
   output logic signed [6:0]          edge8_offset_ns
);
   // ****************************************
   // shadow registers written by the host
   // ****************************************
   logic [7:0]                        pair_c_ff;
   logic [7:0]                        pair_d_ff;
   logic [7:0]                        rdata_ff;
   logic                              ack_ff;
   logic                              hit_ff;

   // host writes land in shadow copies only
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         pair_c_ff <= peo_pkg::RESET_PAIR_C;
         pair_d_ff <= peo_pkg::RESET_PAIR_D;
      end else if (reg_wr) begin
         if (reg_addr == peo_pkg::ADDR_PAIR_C) begin
            pair_c_ff <= reg_wdata;
         end else if (reg_addr == peo_pkg::ADDR_PAIR_D) begin
            pair_d_ff <= reg_wdata;
         end
      end
   end

   // read data, ack and hit one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdata_ff <= peo_pkg::RDATA_UNMAP;
         ack_ff   <= 1'b0;
         hit_ff   <= 1'b0;
      end else begin
         ack_ff <= reg_wr | reg_rd;
         hit_ff <= (reg_wr | reg_rd) &
                   ((reg_addr == peo_pkg::ADDR_PAIR_C) | (reg_addr == peo_pkg::ADDR_PAIR_D));
         if (reg_rd) begin
            if (reg_addr == peo_pkg::ADDR_PAIR_C) begin
               rdata_ff <= pair_c_ff;
            end else if (reg_addr == peo_pkg::ADDR_PAIR_D) begin
               rdata_ff <= pair_d_ff;
            end else begin
               rdata_ff <= peo_pkg::RDATA_UNMAP;
            end
         end
      end
   end

   assign reg_rdata = rdata_ff;
   assign reg_ack   = ack_ff;
   assign reg_hit   = hit_ff;

   // ****************************************
   // active settings, one slot per edge
   // ****************************************
   logic [7:0]                        src [4];
   logic                              dir_ff [4];
   logic [2:0]                        shift_ff [4];
   logic signed [6:0]                 ofs_ff [4];

   assign src[0] = pair_c_ff;
   assign src[1] = pair_c_ff;
   assign src[2] = pair_d_ff;
   assign src[3] = pair_d_ff;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_edge
         localparam int DBIT = (gi % 2 == 0) ? peo_pkg::UPPER_DIR_BIT : peo_pkg::LOWER_DIR_BIT;
         localparam int SLSB = (gi % 2 == 0) ? peo_pkg::UPPER_SHIFT_LSB : peo_pkg::LOWER_SHIFT_LSB;
         logic [2:0]        nxt_shift;
         logic signed [6:0] nxt_mag;
         assign nxt_shift = src[gi][SLSB +: peo_pkg::SHIFT_W];                 // [RULE1] [RULE2] [RULE3] [RULE4]
         assign nxt_mag   = 7'(signed'({4'h0, nxt_shift}) * peo_pkg::STEP_NS);  // 5 ns per code step

         // copy shadow into active only at a period boundary
         always_ff @(posedge clk_sys) begin
            if (rst) begin
               dir_ff[gi]   <= 1'b0;
               shift_ff[gi] <= 3'h0;
               ofs_ff[gi]   <= 7'sh00;
            end else if (period_start) begin                                   // [RULE6]
               dir_ff[gi]   <= src[gi][DBIT];                                  // [RULE5]
               shift_ff[gi] <= nxt_shift;
               ofs_ff[gi]   <= src[gi][DBIT] ? -nxt_mag : nxt_mag;              // [RULE5]
            end
         end
      end
   endgenerate

   // per-edge outputs
   assign edge5_direction = dir_ff[0];
   assign edge5_shift     = shift_ff[0];
   assign edge5_offset_ns = ofs_ff[0];
   assign edge6_direction = dir_ff[1];
   assign edge6_shift     = shift_ff[1];
   assign edge6_offset_ns = ofs_ff[1];
   assign edge7_direction = dir_ff[2];
   assign edge7_shift     = shift_ff[2];
   assign edge7_offset_ns = ofs_ff[2];
   assign edge8_direction = dir_ff[3];
   assign edge8_shift     = shift_ff[3];
   assign edge8_offset_ns = ofs_ff[3];

   // ****************************************
   // assertions
   // ****************************************
   property p_edge5_field;
      @(posedge clk_sys) disable iff (rst)
         period_start |=> (edge5_shift == $past(pair_c_ff[6:4])) &&
                          (edge5_offset_ns == ($past(pair_c_ff[7]) ? -7'(peo_pkg::STEP_NS) : 7'(peo_pkg::STEP_NS)) *
                           signed'({4'h0, $past(pair_c_ff[6:4])}));
   endproperty
   a_edge5_field: assert property (p_edge5_field) else $error("edge5 offset wrong"); // [RULE1]

   property p_edge6_field;
      @(posedge clk_sys) disable iff (rst)
         period_start |=> edge6_shift == $past(pair_c_ff[2:0]);
   endproperty
   a_edge6_field: assert property (p_edge6_field) else $error("edge6 shift wrong"); // [RULE2]

   property p_edge7_field;
      @(posedge clk_sys) disable iff (rst)
         (period_start && pair_d_ff[6:4] == 3'h7 && !pair_d_ff[7]) |=> edge7_offset_ns == 7'(peo_pkg::MAX_NS);
   endproperty
   a_edge7_field: assert property (p_edge7_field) else $error("edge7 max offset not 35"); // [RULE3]

   property p_edge8_field;
      @(posedge clk_sys) disable iff (rst)
         period_start |=> edge8_shift == $past(pair_d_ff[2:0]) &&
                          edge8_offset_ns == ($past(pair_d_ff[3]) ? -7'(peo_pkg::STEP_NS) : 7'(peo_pkg::STEP_NS)) *
                                             signed'({4'h0, $past(pair_d_ff[2:0])});
   endproperty
   a_edge8_field: assert property (p_edge8_field) else $error("edge8 offset wrong"); // [RULE4]

   property p_direction;
      @(posedge clk_sys) disable iff (rst)
         period_start |=> edge5_direction == $past(pair_c_ff[7]) && edge6_direction == $past(pair_c_ff[3]) &&
                          edge7_direction == $past(pair_d_ff[7]) && edge8_direction == $past(pair_d_ff[3]);
   endproperty
   a_direction: assert property (p_direction) else $error("direction bit mismatch"); // [RULE5]

   property p_hold_mid_period;
      @(posedge clk_sys) disable iff (rst)
         !period_start |=> $stable(edge5_offset_ns) && $stable(edge6_offset_ns) &&
                           $stable(edge7_offset_ns) && $stable(edge8_offset_ns);
   endproperty
   a_hold_mid_period: assert property (p_hold_mid_period) else $error("offset moved mid period"); // [RULE6]

   property p_read_back;
      @(posedge clk_sys) disable iff (rst)
         (reg_rd && !reg_wr && reg_addr == peo_pkg::ADDR_PAIR_D) |=> reg_ack && reg_hit &&
                                                                     reg_rdata == pair_d_ff;
   endproperty
   a_read_back: assert property (p_read_back) else $error("read back wrong");

   property p_unmapped;
      @(posedge clk_sys) disable iff (rst)
         (reg_rd && reg_addr != peo_pkg::ADDR_PAIR_C && reg_addr != peo_pkg::ADDR_PAIR_D) |=>
            reg_ack && !reg_hit && reg_rdata == peo_pkg::RDATA_UNMAP;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");

   // every strobe is answered one cycle later
   property p_ack_pulse;
      @(posedge clk_sys) disable iff (rst)
         (reg_wr || reg_rd) |=> reg_ack;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack missing after strobe");

   // no strobe, no answer
   property p_idle_quiet;
      @(posedge clk_sys) disable iff (rst)
         !(reg_wr || reg_rd) |=> !reg_ack && !reg_hit;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("ack or hit without strobe");

   // a write to pair C lands in its shadow copy
   property p_write_lands;
      @(posedge clk_sys) disable iff (rst)
         (reg_wr && reg_addr == peo_pkg::ADDR_PAIR_C) |=> pair_c_ff == $past(reg_wdata);
   endproperty
   a_write_lands: assert property (p_write_lands) else $error("write did not land");

   // read data holds between reads
   property p_rdata_holds;
      @(posedge clk_sys) disable iff (rst)
         !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_holds: assert property (p_rdata_holds) else $error("read data moved without read");

   property p_cov_write_apply;
      @(posedge clk_sys) disable iff (rst)
         (reg_wr && reg_addr == peo_pkg::ADDR_PAIR_C) ##[1:20] period_start;
   endproperty
   c_write_apply: cover property (p_cov_write_apply);

   property p_cov_negative;
      @(posedge clk_sys) disable iff (rst) edge7_offset_ns == -7'(peo_pkg::MAX_NS);
   endproperty
   c_negative: cover property (p_cov_negative);

   property p_cov_both_strobes;
      @(posedge clk_sys) disable iff (rst) reg_wr && reg_rd && reg_addr == peo_pkg::ADDR_PAIR_C;
   endproperty
   c_both_strobes: cover property (p_cov_both_strobes);

   property p_cov_unmapped;
      @(posedge clk_sys) disable iff (rst) reg_ack && !reg_hit;
   endproperty
   c_unmapped: cover property (p_cov_unmapped);
endmodule

/* verilog/peo_pkg.sv */
// How it works
// RULE1 - edge five shifts by reg c [6:4]
// RULE2 - edge six shifts by reg c [2:0]
// RULE3 - edge seven shifts by reg d [6:4]
// RULE4 - edge eight shifts by reg d [2:0]
// RULE5 - bits 7/3 choose direction, 1 negative
// RULE6 - new settings apply at next period start
package peo_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam logic [7:0] ADDR_PAIR_C  = 8'h6B;
   localparam logic [7:0] ADDR_PAIR_D  = 8'h6C;
   localparam logic [7:0] RESET_PAIR_C = 8'h00;
   localparam logic [7:0] RESET_PAIR_D = 8'h00;
   localparam logic [7:0] RDATA_UNMAP  = 8'h00;

   // ****************************************
   // field layout
   // ****************************************
   localparam int UPPER_DIR_BIT   = 7;
   localparam int UPPER_SHIFT_LSB = 4;
   localparam int LOWER_DIR_BIT   = 3;
   localparam int LOWER_SHIFT_LSB = 0;
   localparam int SHIFT_W         = 3;

   // ****************************************
   // timing
   // ****************************************
   localparam int STEP_NS = 5;
   localparam int MAX_NS  = 35;
   localparam int OFS_W   = 7;
endpackage

/* testbench/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   // ****************************************
   // signals and bench state
   // ****************************************
   localparam logic [7:0] A_C = peo_pkg::ADDR_PAIR_C;
   localparam logic [7:0] A_D = peo_pkg::ADDR_PAIR_D;
   logic              clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, period_start = 1'b0;
   logic       [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
   logic              reg_ack, reg_hit, ps_q = 1'b0;
   logic              e5_d, e6_d, e7_d, e8_d;
   logic       [2:0]  e5_s, e6_s, e7_s, e8_s;
   logic signed [6:0] e5_o, e6_o, e7_o, e8_o;
   logic       [7:0]  sh_c = 8'h00, sh_d = 8'h00, last_rd = 8'h00;
   logic       [31:0] lf = 32'h8E7EFE9F;
   logic       [8:0]  rq[$];
   logic       [43:0] eq[$];
   logic       [43:0] act_exp = 44'h000, tmp, obs;
   int                num_errors = 0, checks = 0;

   peo_edge_offset_regs dut (.clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
      .reg_hit(reg_hit), .period_start(period_start),
      .edge5_direction(e5_d), .edge5_shift(e5_s), .edge5_offset_ns(e5_o),
      .edge6_direction(e6_d), .edge6_shift(e6_s), .edge6_offset_ns(e6_o),
      .edge7_direction(e7_d), .edge7_shift(e7_s), .edge7_offset_ns(e7_o),
      .edge8_direction(e8_d), .edge8_shift(e8_s), .edge8_offset_ns(e8_o));

   // 100 ns clock
   initial forever #50 clk_sys = ~clk_sys;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] lfsr_step(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // direction, code and signed offset of one nibble
   function automatic logic [10:0] fld(input logic [3:0] n);
      logic [6:0] m;
      m = 7'(n[2:0]) * 7'(peo_pkg::STEP_NS);
      return {n[3], n[2:0], n[3] ? -m : m};
   endfunction

   task automatic chk(input string nm, input logic [43:0] e, input logic [43:0] s);
      checks++;
      if (e !== s) begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask

   // one cycle of stimulus at the falling edge, expectations queued
   task automatic step(input logic wr, input logic rd, input logic [7:0] a, input logic [7:0] d,
                       input logic ps);
      @(negedge clk_sys);
      reg_wr = wr; reg_rd = rd; reg_addr = a; reg_wdata = d; period_start = ps;
      if (rd) last_rd = (a == A_C) ? sh_c : (a == A_D) ? sh_d : peo_pkg::RDATA_UNMAP;
      if (wr | rd) rq.push_back({(a == A_C) || (a == A_D), last_rd});
      if (ps) eq.push_back({fld(sh_c[7:4]), fld(sh_c[3:0]), fld(sh_d[7:4]), fld(sh_d[3:0])});
      if (wr && a == A_C) sh_c = d;
      if (wr && a == A_D) sh_d = d;
   endtask

   task automatic give_verdict;
      if (rq.size() != 0 || eq.size() != 0) num_errors++;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ****************************************
   // monitor: take oldest note when a result appears
   // ****************************************
   always @(posedge clk_sys) ps_q <= period_start & ~rst;
   always @(negedge clk_sys) begin
      if (rst) act_exp = 44'h000;
      if (ps_q) act_exp = eq.pop_front();
      obs = {e5_d, e5_s, e5_o, e6_d, e6_s, e6_o, e7_d, e7_s, e7_o, e8_d, e8_s, e8_o};
      if (!rst) chk("edge outputs", act_exp, obs);
      if (reg_ack && rq.size() == 0) chk("stray ack", 44'h000, 44'h001);
      else if (reg_ack) begin
         tmp = 44'(rq.pop_front());
         chk("read port", tmp, {35'h0, reg_hit, reg_rdata});
      end
   end

   // watchdog well beyond the expected run of about 140 cycles
   initial begin
      repeat (3000) @(posedge clk_sys);
      num_errors++;
      give_verdict();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      repeat (6) @(negedge clk_sys);
      rst = 1'b0;
      step(1'b0, 1'b1, A_C, 8'h00, 1'b0);
      step(1'b0, 1'b1, A_D, 8'h00, 1'b1);
      // every code and direction, outputs held until period start
      for (int k = 0; k < 16; k++) begin
         step(1'b1, 1'b0, A_C, {4'(k), ~4'(k)}, 1'b0);
         step(1'b1, 1'b0, A_D, {~4'(k), 4'(k)}, 1'b0);
         step(1'b0, 1'b1, A_C, 8'h00, 1'b0);
         step(1'b0, 1'b0, 8'h00, 8'h00, 1'b1);
      end
      // random traffic, write with period start, unmapped places
      for (int k = 0; k < 12; k++) begin
         lf = lfsr_step(lf);
         step(1'b1, 1'b1, A_C, lf[7:0], lf[8]);
         step(1'b1, 1'b0, A_D, lf[15:8], 1'b0);
         step(1'b0, 1'b1, lf[23:16], 8'h00, 1'b0);
         step(1'b1, 1'b0, lf[31:24], lf[7:0], 1'b0);
         step(1'b0, 1'b1, A_D, 8'h00, 1'b1);
      end
      // second reset in mid-run clears everything
      step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
      step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
      rst = 1'b1;
      sh_c = 8'h00; sh_d = 8'h00; last_rd = 8'h00;
      repeat (2) @(negedge clk_sys);
      rst = 1'b0;
      step(1'b0, 1'b1, A_C, 8'h00, 1'b1);
      step(1'b0, 1'b0, 8'h00, 8'h00, 1'b0);
      repeat (3) @(negedge clk_sys);
      give_verdict();
   end
endmodule
